// [design/eira_top.sv]
// eira_top: external interrupt request and acknowledge logic with register slave
// assumes asynchronous pin inputs, one 200 MHz clock, avalon-mm slave with waitrequest
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module eira_top
  import eira_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // interrupt pins
  input  wire logic [2:0]  interrupt_request_lines,
  // acknowledge bus
  output logic [31:0]      bus_addr,
  output logic [1:0]       transfer_type_lines,
  output logic [2:0]       transfer_modifier_lines,
  output logic             bus_read,
  output logic             addr_valid_strobe_n,
  input  wire logic        transfer_ack_in_n,
  input  wire logic [31:0] bus_data_in,
  // core side
  input  wire logic        instr_boundary,
  output logic             take_irq,
  output logic [7:0]       vector_num,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq
);
  eira_req_if req_w ();             // filtered request level
  eira_state_t state_q;             // acknowledge sequencer
  logic [2:0]  mask_lvl_q;          // first-stage mask level
  logic [2:0]  core_mask_q;         // core_state_word mask
  logic [1:0]  ctrl_q;              // self_vector_enable, ack_cycle_block
  logic [2:0]  ien_q;               // interrupt enable mask
  logic [2:0]  ack_lvl_q;           // level under acknowledge
  logic        nmi_armed_q;         // level 7 edge waiting
  logic        wr_en;               // avalon write accepted this edge
  logic        step_q;              // one handler step done
  logic [2:0]  ev_set;              // event strobes
  logic [2:0]  ev_flag;             // sticky status
  logic [2:0]  unit_lvl;            // after first stage
  logic        pend;                // pending after both stages
  logic        bus_done;            // bus access terminated this cycle
  logic        wr_st;               // write to status

  eira_req_filter u_filt (
    .core_clk                (core_clk),
    .reset_n                 (reset_n),
    .interrupt_request_lines (interrupt_request_lines),
    .req                     (req_w)
  );

  // first stage: unit mask passes only levels above it; zero is no request
  always_comb begin
    unit_lvl = EIRA_LVL_NONE;
    if (req_w.level != EIRA_LVL_NONE && req_w.level > mask_lvl_q) begin
      unit_lvl = req_w.level;
    end
  end

  // second stage: core mask; level 7 bypasses it but needs an edge or a lowered mask
  always_comb begin
    if (unit_lvl == EIRA_LVL_NMI) begin
      pend = nmi_armed_q || (core_mask_q < EIRA_LVL_NMI);
    end else begin
      // levels one to six pend for as long as they are held above the mask
      pend = (unit_lvl != EIRA_LVL_NONE) && (unit_lvl > core_mask_q);
    end
  end

  // take decision at an instruction boundary
  // both stages must pass, and the last handler must have run one step
  function automatic logic take_now();
    take_now = pend && instr_boundary && step_q;
  endfunction

  // level 7 edge arming
  // the edge is used up by the take itself, so a held level 7 is taken once, or twice if first taken in the cycle of its rise,
  // also on the self vector path that never passes through the bus states
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      // nothing armed out of reset
      nmi_armed_q <= 1'b0;
    end else if (req_w.nmi_edge) begin
      // a fresh rise into level 7 wins over any clear
      nmi_armed_q <= 1'b1;
    end else if (state_q == EIRA_IDLE && take_now() && unit_lvl == EIRA_LVL_NMI) begin
      // the level 7 being taken consumes the edge
      nmi_armed_q <= 1'b0;
    end else if (req_w.level != EIRA_LVL_NMI) begin
      // request left level 7 before it was taken
      nmi_armed_q <= 1'b0;
    end
  end

  // acknowledge sequencer
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q   <= EIRA_IDLE;
      ack_lvl_q <= EIRA_LVL_NONE;
      take_irq  <= 1'b0;
    end else begin
      take_irq <= 1'b0;
      unique case (state_q)
        EIRA_IDLE: begin
          if (take_now()) begin
            ack_lvl_q <= unit_lvl;
            take_irq  <= 1'b1;
            // self vector with block set: no bus cycle
            if (ctrl_q[EIRA_CTRL_SELF_VECTOR_ENABLE_BIT] && ctrl_q[EIRA_CTRL_BLK_BIT]) begin
              state_q <= EIRA_HNDLR;
            end else begin
              state_q <= EIRA_S0;
            end
          end
        end
        EIRA_S0: begin
          // address and attributes settle for one cycle
          state_q <= EIRA_S1;
        end
        EIRA_S1: begin
          // strobe now low, start looking for termination
          state_q <= EIRA_S3;
        end
        EIRA_S3: begin
          // stay here one whole clock per wait state
          if (!transfer_ack_in_n) begin
            state_q <= EIRA_S5;
          end
        end
        EIRA_S5: begin
          // strobe released, bus cycle over
          state_q <= EIRA_HNDLR;
        end
        EIRA_HNDLR: begin
          // handler entry; recognition waits for its first step
          state_q <= EIRA_IDLE;
        end
      endcase
    end
  end

  // one handler step must pass before the next request is recognised
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      step_q <= 1'b1;
    end else if (state_q == EIRA_HNDLR) begin
      // handler entered: no step has run yet
      step_q <= 1'b0;
    end else if (instr_boundary) begin
      // first boundary inside the handler opens recognition again
      step_q <= 1'b1;
    end
  end

  // acknowledge bus pins
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      bus_addr                <= 32'h0;
      transfer_type_lines     <= 2'h0;
      transfer_modifier_lines <= 3'h0;
      bus_read                <= 1'b0;
      addr_valid_strobe_n     <= 1'b1;
    end else if (state_q == EIRA_IDLE && take_now() &&
                 !(ctrl_q[EIRA_CTRL_SELF_VECTOR_ENABLE_BIT] && ctrl_q[EIRA_CTRL_BLK_BIT])) begin
      bus_addr                <= {EIRA_ADDR_HIGH, unit_lvl, EIRA_ADDR_LOW};
      transfer_type_lines     <= EIRA_TT_ACK;
      transfer_modifier_lines <= unit_lvl;
      bus_read                <= 1'b1;
    end else if (state_q == EIRA_S0) begin
      // attributes have stood one cycle, strobe them
      addr_valid_strobe_n <= 1'b0;
    end else if (state_q == EIRA_S3 && !transfer_ack_in_n) begin
      // terminated: release strobe and return all lines to idle
      addr_valid_strobe_n     <= 1'b1;
      bus_read                <= 1'b0;
      transfer_type_lines     <= 2'h0;
      transfer_modifier_lines <= 3'h0;
      bus_addr                <= 32'h0;
    end
  end

  // vector capture: responder byte, or internal autovector
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      vector_num <= 8'h0;
    end else if (state_q == EIRA_S3 && !transfer_ack_in_n) begin
      // cycle shown on the bus; self vector still overrides the byte
      if (ctrl_q[EIRA_CTRL_SELF_VECTOR_ENABLE_BIT]) begin
        vector_num <= EIRA_AUTOVEC_BASE + {5'h0, ack_lvl_q};
      end else begin
        vector_num <= bus_data_in[31:24];
      end
    end else if (state_q == EIRA_IDLE && take_now() &&
                 ctrl_q[EIRA_CTRL_SELF_VECTOR_ENABLE_BIT] && ctrl_q[EIRA_CTRL_BLK_BIT]) begin
      vector_num <= EIRA_AUTOVEC_BASE + {5'h0, unit_lvl};
    end
  end

  // core mask: raised to the taken level when an interrupt is taken
  // a handler that lowers the mask under a held level 7 gets a second take,
  // and that take puts the mask back to 7; restoring it any earlier would
  // race the instruction boundary and could swallow the second take
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      // all levels but 7 ignored out of reset
      core_mask_q <= EIRA_RST_CORE;
    end else if (state_q == EIRA_IDLE && take_now()) begin
      // taking level 7 again sets the mask back to 7
      core_mask_q <= unit_lvl;
    end else if (wr_en && avs_address == {1'b0, EIRA_OFF_CORE}) begin
      // software, e.g. a handler returning, writes the mask
      core_mask_q <= avs_writedata[2:0];
    end
  end

  // software written configuration
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mask_lvl_q <= EIRA_RST_MASK_LVL;
      ctrl_q     <= EIRA_RST_CTRL;
      ien_q      <= 3'h0;
    end else if (wr_en) begin
      // a write lands only at the edge that completes the transfer
      if (avs_address == {1'b0, EIRA_OFF_MASK_LVL}) mask_lvl_q <= avs_writedata[2:0];
      if (avs_address == {1'b0, EIRA_OFF_CTRL})     ctrl_q     <= avs_writedata[1:0];
      if (avs_address == EIRA_OFF_IEN)              ien_q      <= avs_writedata[2:0];
    end
  end

  // event strobes and sticky status bits
  assign bus_done = (state_q == EIRA_S3) && !transfer_ack_in_n;
  // avalon writes take effect only once waitrequest is seen low
  assign wr_en    = avs_write && !avs_waitrequest;
  assign wr_st    = wr_en && (avs_address == {1'b0, EIRA_OFF_STATUS});
  assign ev_set   = {take_irq && ack_lvl_q == EIRA_LVL_NMI, bus_done, take_irq};
  for (genvar i = 0; i < EIRA_NUM_EV; i++) begin : g_ev
    eira_evt_bit u_ev (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .set      (ev_set[i]),
      .clr      (wr_st && avs_writedata[i]),
      .flag     (ev_flag[i])
    );
  end

  // interrupt output: any unmasked sticky bit
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      // level output, one cycle behind the sticky bits
      irq <= |(ev_flag & ien_q);
    end
  end

  // avalon slave: one wait state for every read and write
  // waitrequest idles high, drops for the one cycle that ends a transfer,
  // and rises again at that edge, so a request held on never completes in two cycles running
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      // stall the bus while in reset
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      // read data is captured in the stall cycle and stands at the ending edge
      if (avs_read && avs_waitrequest) begin
        unique case (avs_address)
          {1'b0, EIRA_OFF_MASK_LVL}: avs_readdata <= {29'h0, mask_lvl_q};
          {1'b0, EIRA_OFF_CORE}:     avs_readdata <= {29'h0, core_mask_q};
          {1'b0, EIRA_OFF_CTRL}:     avs_readdata <= {30'h0, ctrl_q};
          {1'b0, EIRA_OFF_STATUS}:   avs_readdata <= {29'h0, ev_flag};
          EIRA_OFF_IEN:              avs_readdata <= {29'h0, ien_q};
          EIRA_OFF_INFO:             avs_readdata <= {21'h0, ack_lvl_q, vector_num};
          default:                   avs_readdata <= 32'h0;
        endcase
      end
    end
  end
endmodule

// [common/eira_pkg.sv]
// eira_pkg: constants and types shared by the external interrupt request and acknowledge block
// assumes a 200 MHz core clock and an avalon-mm register slave with 32-bit data
package eira_pkg;
  // register byte offsets
  localparam logic [3:0] EIRA_OFF_MASK_LVL = 4'h0; // first-stage mask level
  localparam logic [3:0] EIRA_OFF_CORE     = 4'h4; // core_state_word priority mask
  localparam logic [3:0] EIRA_OFF_CTRL     = 4'h8; // self_vector_enable, ack_cycle_block
  localparam logic [3:0] EIRA_OFF_STATUS   = 4'hc; // sticky event bits, write one to clear
  localparam logic [4:0] EIRA_OFF_IEN      = 5'h10; // interrupt enable mask
  localparam logic [4:0] EIRA_OFF_INFO     = 5'h14; // last level, last vector
  // control word fields
  localparam int EIRA_CTRL_SELF_VECTOR_ENABLE_BIT = 0;
  localparam int EIRA_CTRL_BLK_BIT  = 1;
  localparam int EIRA_CTRL_SRV_BIT  = 2; // unused; ctrl_q keeps bits 0 and 1 only, so a write to bit 2 is dropped
  // status bit positions
  localparam int EIRA_ST_TAKEN = 0; // an interrupt was taken
  localparam int EIRA_ST_ACKED = 1; // acknowledge cycle finished
  localparam int EIRA_ST_NMI   = 2; // level 7 taken
  localparam int EIRA_NUM_EV   = 3;
  // reset values
  localparam logic [2:0] EIRA_RST_MASK_LVL = 3'h0;
  localparam logic [2:0] EIRA_RST_CORE     = 3'h7;
  localparam logic [1:0] EIRA_RST_CTRL     = 2'h0;
  // acknowledge encodings
  localparam logic [1:0]  EIRA_TT_ACK     = 2'h3;
  localparam logic [26:0] EIRA_ADDR_HIGH  = 27'h7ffffff;
  localparam logic [1:0]  EIRA_ADDR_LOW   = 2'h0;
  localparam logic [2:0]  EIRA_LVL_NMI    = 3'h7;
  localparam logic [2:0]  EIRA_LVL_NONE   = 3'h0;
  localparam logic [7:0]  EIRA_AUTOVEC_BASE = 8'h18; // autovector = base + level
  // sample stability count, in bus clock periods
  localparam int EIRA_STABLE_CLKS = 2;
  // acknowledge sequencer states, one-hot
  typedef enum logic [5:0] {
    EIRA_IDLE  = 6'b000001, // waiting for a pending request
    EIRA_S0    = 6'b000010, // address and attributes out
    EIRA_S1    = 6'b000100, // address strobe asserted
    EIRA_S3    = 6'b001000, // wait for transfer acknowledge
    EIRA_S5    = 6'b010000, // strobe released
    EIRA_HNDLR = 6'b100000  // handler running
  } eira_state_t;
endpackage

// [common/eira_req_if.sv]
// eira_req_if: carries the validated request level between filter and core
// assumes one clock domain
`timescale 1ns/1ps
interface eira_req_if;
  logic [2:0] level;   // stable encoded request level
  logic       nmi_edge; // one-cycle pulse on a rise into level 7
  modport src (output level, output nmi_edge);
  modport dst (input level, input nmi_edge);
endinterface

// [design/eira_req_filter.sv]
// eira_req_filter: synchronises and validates the encoded request lines
// assumes request lines come from the pins, one clock domain
`timescale 1ns/1ps
module eira_req_filter
  import eira_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic [2:0] interrupt_request_lines,
  eira_req_if.src         req
);
  logic [2:0] sync1_q;  // first synchroniser stage
  logic [2:0] sync2_q;  // second synchroniser stage
  logic [2:0] prev_q;   // previous synchronised sample
  logic [1:0] same_q;   // periods the sample has held
  logic [2:0] level_q;  // accepted level
  logic       edge_q;   // level 7 rise pulse

  // two-flop synchroniser
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      sync1_q <= EIRA_LVL_NONE;
      sync2_q <= EIRA_LVL_NONE;
    end else begin
      sync1_q <= interrupt_request_lines;
      sync2_q <= sync1_q;
    end
  end

  // stability counter and acceptance
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      prev_q  <= EIRA_LVL_NONE;
      same_q  <= 2'h0;
      level_q <= EIRA_LVL_NONE;
      edge_q  <= 1'b0;
    end else begin
      prev_q <= sync2_q;
      edge_q <= 1'b0;
      if (sync2_q != prev_q) begin
        same_q <= 2'h0;
      end else if (same_q < 2'(EIRA_STABLE_CLKS - 1)) begin
        same_q <= same_q + 2'h1;
      end else begin
        // held two consecutive periods: accept
        level_q <= sync2_q;
        // only a rise from lower into level 7 counts
        edge_q  <= (sync2_q == EIRA_LVL_NMI) && (level_q != EIRA_LVL_NMI);
      end
    end
  end

  assign req.level    = level_q;
  assign req.nmi_edge = edge_q;
endmodule

// [design/eira_evt_bit.sv]
// eira_evt_bit: one sticky event bit, write one to clear, set wins
// assumes one clock domain
`timescale 1ns/1ps
module eira_evt_bit (
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);
  // sticky flag; a set in the clear cycle survives
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      flag <= 1'b0;
    end else if (set) begin
      flag <= 1'b1;
    end else if (clr) begin
      flag <= 1'b0;
    end
  end
endmodule

// [verification/eira_resp_model.sv]
// eira_resp_model: vector responder on the far side of the acknowledge bus
// assumes active low strobe and termination, one clock shared with the block
`timescale 1ns/1ps
module eira_resp_model (
  input  wire logic        core_clk,
  input  wire logic        addr_valid_strobe_n,
  input  wire logic        bus_read,
  input  wire logic [7:0]  vec,
  input  wire logic [1:0]  wait_clks,
  output logic             transfer_ack_in_n,
  output logic [31:0]      bus_data_in
);
  logic [2:0] cnt_q; // stalls inserted so far
  initial begin
    transfer_ack_in_n = 1'b1;
    bus_data_in = 32'h0;
    cnt_q = 3'h0;
  end
  // stall wait_clks cycles, then terminate for exactly one cycle
  always @(posedge core_clk) begin
    bus_data_in <= ~bus_data_in; // released lines keep toggling
    if (!transfer_ack_in_n || addr_valid_strobe_n || !bus_read) begin
      transfer_ack_in_n <= 1'b1;
      cnt_q <= 3'h0;
    end else if (cnt_q >= {1'b0, wait_clks}) begin
      transfer_ack_in_n <= 1'b0;
      bus_data_in <= {vec, 24'h5a5a5a};
    end else begin
      cnt_q <= cnt_q + 3'h1;
    end
  end
endmodule

// [verification/eira_top_checker.sv]
// eira_top_checker: timing and encoding checks on the acknowledge bus
// assumes it is bound into eira_top and sees only its ports
`timescale 1ns/1ps
module eira_top_checker
  import eira_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic [31:0] bus_addr,
  input wire logic [1:0]  transfer_type_lines,
  input wire logic [2:0]  transfer_modifier_lines,
  input wire logic        bus_read,
  input wire logic        addr_valid_strobe_n,
  input wire logic        transfer_ack_in_n,
  input wire logic        instr_boundary,
  input wire logic        take_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  property p_ack_type;
    !addr_valid_strobe_n |-> transfer_type_lines == EIRA_TT_ACK && bus_read;
  endproperty
  a_ack_type: assert property (p_ack_type) else $error("ack type wrong");
  property p_ack_addr;
    !addr_valid_strobe_n |->
      bus_addr == {EIRA_ADDR_HIGH, transfer_modifier_lines, EIRA_ADDR_LOW};
  endproperty
  a_ack_addr: assert property (p_ack_addr) else $error("ack address wrong");
  property p_lvl_nz;
    !addr_valid_strobe_n |-> transfer_modifier_lines != EIRA_LVL_NONE;
  endproperty
  a_lvl_nz: assert property (p_lvl_nz) else $error("ack for level zero");
  property p_wait;
    !addr_valid_strobe_n && transfer_ack_in_n |=> !addr_valid_strobe_n;
  endproperty
  a_wait: assert property (p_wait) else $error("strobe left early");
  property p_end;
    !addr_valid_strobe_n && !transfer_ack_in_n |=> addr_valid_strobe_n;
  endproperty
  a_end: assert property (p_end) else $error("strobe held after ack");
  property p_setup;
    $fell(addr_valid_strobe_n) |-> $past(transfer_type_lines) == EIRA_TT_ACK;
  endproperty
  a_setup: assert property (p_setup) else $error("strobe before setup");
  property p_pulse;
    take_irq |=> !take_irq;
  endproperty
  a_pulse: assert property (p_pulse) else $error("take not a pulse");
  property p_bnd;
    take_irq |-> $past(instr_boundary);
  endproperty
  a_bnd: assert property (p_bnd) else $error("take off boundary");
  property p_hold;
    !addr_valid_strobe_n [*2] |-> $stable(transfer_modifier_lines);
  endproperty
  a_hold: assert property (p_hold) else $error("level moved in ack");
  property p_idle;
    !bus_read |-> transfer_type_lines == 2'h0;
  endproperty
  a_idle: assert property (p_idle) else $error("type out of ack");
endmodule
bind eira_top eira_top_checker eira_top_checker_i (.core_clk(core_clk), .reset_n(reset_n),
  .bus_addr(bus_addr), .transfer_type_lines(transfer_type_lines),
  .transfer_modifier_lines(transfer_modifier_lines), .bus_read(bus_read),
  .addr_valid_strobe_n(addr_valid_strobe_n), .transfer_ack_in_n(transfer_ack_in_n),
  .instr_boundary(instr_boundary), .take_irq(take_irq));

// [verification/eira_tb_top.sv]
// eira_tb_top: self-checking bench for the interrupt request and acknowledge block
// assumes eira_top, the responder model and the bound checker
`timescale 1ns/1ps
module eira_tb_top;
  import eira_pkg::*;
  localparam logic [4:0] r_msk = {1'b0, EIRA_OFF_MASK_LVL};
  localparam logic [4:0] r_cor = {1'b0, EIRA_OFF_CORE};
  localparam logic [4:0] r_ctl = {1'b0, EIRA_OFF_CTRL};
  localparam logic [4:0] r_st  = {1'b0, EIRA_OFF_STATUS};
  logic        core_clk, reset_n, instr_boundary, avs_read, avs_write, bus_read;
  logic        addr_valid_strobe_n, transfer_ack_in_n, take_irq, avs_waitrequest, irq;
  logic [2:0]  interrupt_request_lines, transfer_modifier_lines, cap_m;
  logic [1:0]  transfer_type_lines, wait_clks;
  logic [4:0]  avs_address;
  logic [7:0]  vector_num, vec;
  logic [31:0] avs_writedata, avs_readdata, bus_addr, bus_data_in, rdat, cap_a;
  int          bad_count = 0, samples_checked = 0, acks = 0, takes = 0, tk, ak, l, m;
  eira_top eira_top_i (.core_clk(core_clk), .reset_n(reset_n),
    .interrupt_request_lines(interrupt_request_lines), .bus_addr(bus_addr),
    .transfer_type_lines(transfer_type_lines), .bus_read(bus_read),
    .transfer_modifier_lines(transfer_modifier_lines), .bus_data_in(bus_data_in),
    .addr_valid_strobe_n(addr_valid_strobe_n), .transfer_ack_in_n(transfer_ack_in_n),
    .instr_boundary(instr_boundary), .take_irq(take_irq), .vector_num(vector_num),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  eira_resp_model eira_resp_model_i (.core_clk(core_clk), .bus_read(bus_read),
    .addr_valid_strobe_n(addr_valid_strobe_n), .vec(vec), .wait_clks(wait_clks),
    .transfer_ack_in_n(transfer_ack_in_n), .bus_data_in(bus_data_in));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // random boundaries; count takes and finished acks, keep the ack address
  always @(posedge core_clk) begin
    instr_boundary <= reset_n && $urandom_range(0, 3) != 0;
    if (take_irq === 1'b1) takes <= takes + 1;
    if (addr_valid_strobe_n === 1'b0 && transfer_ack_in_n === 1'b0) begin
      acks <= acks + 1;
      cap_a <= bus_addr;
      cap_m <= transfer_modifier_lines;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [4:0] a, input int d);
    int n;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= 32'(d);
    avs_write <= w;
    avs_read <= !w;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n == 20) begin bad_count++; final_report(); end
  endtask
  // bounded wait for a counter to reach a target
  task automatic wt(ref int c, input int tgt);
    int n;
    for (n = 0; n < 60 && c < tgt; n++) @(posedge core_clk);
    if (c < tgt) begin bad_count++; final_report(); end
  endtask
  initial begin
    {reset_n, avs_read, avs_write} = 3'h0;
    {interrupt_request_lines, avs_address, avs_writedata, vec, wait_clks} = '0;
    void'($urandom(32'h90f98802));
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    acc(0, r_cor, 0); chk("core reset", rdat, 32'h7);
    acc(0, r_msk, 0); chk("mask reset", rdat, 32'h0);
    acc(0, 5'h18, 0); chk("unmapped", rdat, 32'h0);
    $display("test registers done");
    for (l = 1; l <= 6; l++) begin
      vec <= 8'($urandom);
      wait_clks <= 2'($urandom);
      tk = takes;
      ak = acks;
      m = $urandom_range(0, 1); // block in the unit stage or in the core stage
      acc(1, r_msk, m ? l : 0);
      acc(1, r_cor, m ? 0 : l);
      interrupt_request_lines <= 3'(l);
      repeat (10) @(posedge core_clk);
      chk("masked", takes, tk);
      acc(1, r_cor, l - 1); // core first, so the take's own raise is not undone
      acc(1, r_msk, l - 1);
      wt(takes, tk + 1);
      wt(acks, ak + 1);
      chk("vector", vector_num, vec);
      chk("ack addr", cap_a, {27'h7ffffff, 3'(l), 2'b00});
      chk("ack level", cap_m, l);
      acc(1, r_cor, l - 1); // handler returns, mask drops back
      wt(takes, tk + 2);
      wt(acks, ak + 2);
      interrupt_request_lines <= 3'h0;
      acc(1, r_ctl, 4);
    end
    $display("test levels done");
    acc(0, r_st, 0); chk("status", rdat, 32'h3);
    acc(1, EIRA_OFF_IEN, 0); chk("irq off", irq, 0);
    acc(1, EIRA_OFF_IEN, 7); acc(0, r_st, 0); chk("irq on", irq, 1);
    acc(1, r_st, 7); acc(0, r_st, 0); chk("cleared", rdat, 0);
    chk("irq gone", irq, 0);
    acc(1, r_msk, 0);
    acc(1, r_cor, 0);
    for (m = 1; m <= 3; m += 2) begin
      acc(1, r_ctl, m);
      acc(1, r_cor, 0); // undo the mask raised by the previous take
      tk = takes;
      ak = acks;
      l = $urandom_range(1, 6);
      interrupt_request_lines <= 3'(l);
      wt(takes, tk + 1);
      repeat (12) @(posedge core_clk);
      chk("bus cycle", acks, ak + (m == 1));
      if (m == 3) chk("autovector", vector_num, EIRA_AUTOVEC_BASE + 8'(l));
      interrupt_request_lines <= 3'h0;
      acc(1, r_ctl, m | 4);
    end
    $display("test autovector done");
    acc(1, r_cor, 7);
    acc(1, r_ctl, 0);
    tk = takes;
    ak = acks;
    interrupt_request_lines <= 3'h7;
    wt(takes, tk + 1);
    wt(acks, ak + 1);
    acc(1, r_cor, 0);
    acc(1, r_ctl, 4);
    wt(takes, tk + 2);
    wt(acks, ak + 2);
    acc(1, r_ctl, 4); acc(0, r_cor, 0); chk("mask back", rdat, 7);
    repeat (15) @(posedge core_clk);
    chk("held top level", takes, tk + 2);
    interrupt_request_lines <= 3'h0;
    repeat (4) @(posedge core_clk);
    interrupt_request_lines <= 3'h7;
    wt(takes, tk + 3);
    wt(acks, ak + 3);
    acc(0, r_st, 0); chk("status top", rdat, 32'h7);
    $display("test top level done");
    final_report();
  end
endmodule
